// ### logic/gcarb_top.sv
// Purpose: general control register with top-level bus arbitration
// Assumes: configuration write/read at byte offsets, global reset only
// Notes: read data and control outputs are registered
`timescale 1ns/1ps
module gcarb_top
    import gcarb_pkg::*;
(
    input  wire logic            clk,
    input  wire logic            reset_n,
    input  wire gcarb_pkg::gcarb_cfg_t cfg,
    input  wire logic [1:0]      media_power_request,
    input  wire logic [gcarb_pkg::NREQ-1:0] bus_req,
    output logic      [15:0]     cfg_rdata,
    output logic                 cfg_rvalid,
    output logic      [1:0]      media_power_outputs,
    output gcarb_pkg::gcarb_ctrl_t ctrl,
    output logic      [gcarb_pkg::NREQ-1:0] bus_grant
);
    import gcarb_pkg::*;

    logic [15:0] gc;
    logic [15:0] next_gc;
    logic [15:0] gc_view;
    logic        hit;
    logic [1:0]  arr_new;

    function automatic logic [15:0] view(input logic [15:0] g);
        logic [15:0] v;
        v = g;
        if (g[B_ARR_HI:B_ARR_LO] != ARR_TWO_IN_ONE) begin
            v[B_STYLE] = 1'b0; // R3
        end
        return v;
    endfunction : view

    assign hit     = (cfg.addr == GC_OFFSET);
    assign gc_view = view(gc);

    always_comb begin
        next_gc = gc;
        if (cfg.wr && hit) begin
            if (cfg.byte_en[0]) begin
                next_gc[7:0] = cfg.wdata[7:0]; // R10 R11 R13
            end
            if (cfg.byte_en[1]) begin
                next_gc[15:8] = cfg.wdata[15:8]; // R1 R2 R5 R6 R7 R8 R9
            end
        end
        arr_new = next_gc[B_ARR_HI:B_ARR_LO];
        // style judged against the arrangement after this write
        if (arr_new != ARR_TWO_IN_ONE) begin
            next_gc[B_STYLE] = 1'b0; // R3 R4
        end
        if (!next_gc[B_SKTB_OFF]) begin
            next_gc[B_SC_PWR] = 1'b0; // R12
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            gc <= GC_RESET; // R15
        end else begin
            gc <= next_gc;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cfg_rdata  <= '0;
            cfg_rvalid <= 1'b0;
        end else begin
            cfg_rvalid <= cfg.rd;
            cfg_rdata  <= (cfg.rd && hit) ? gc_view : '0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl <= GC_RESET;
        end else begin
            ctrl <= view(next_gc); // R2 R5 R6 R7 R8 R9 R10 R11
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            media_power_outputs <= 2'h3;
        end else if (next_gc[B_POL]) begin
            media_power_outputs <= media_power_request; // R1
        end else begin
            media_power_outputs <= ~media_power_request; // R1
        end
    end

    gcarb_arbiter u_arb (
        .clk     (clk),
        .reset_n (reset_n),
        .mode    (gc[B_PRI_HI:B_PRI_LO]),
        .req     (bus_req),
        .grant   (bus_grant)
    );

    property p_style_gate;
        @(posedge clk) disable iff (!reset_n)
        gc[B_ARR_HI:B_ARR_LO] != ARR_TWO_IN_ONE |-> !gc[B_STYLE] && !ctrl.smartcard_style_select;
    endproperty
    a_style_gate: assert property (p_style_gate) else $error("style set outside 2-in-1"); // R3
    property p_joint_write;
        @(posedge clk) disable iff (!reset_n)
        (cfg.wr && hit && cfg.byte_en[1] && cfg.wdata[B_STYLE]
         && cfg.wdata[B_ARR_HI:B_ARR_LO] == ARR_TWO_IN_ONE) |=> gc[B_STYLE];
    endproperty
    a_joint_write: assert property (p_joint_write) else $error("joint write lost style"); // R4
    property p_vpp_gate;
        @(posedge clk) disable iff (!reset_n) gc[B_SC_PWR] |-> gc[B_SKTB_OFF];
    endproperty
    a_vpp_gate: assert property (p_vpp_gate) else $error("vpp source while socket on"); // R12
    property p_polarity;
        @(posedge clk) disable iff (!reset_n)
        1'b1 |=> media_power_outputs == (gc[B_POL] ? $past(media_power_request)
            : ~$past(media_power_request));
    endproperty
    a_polarity: assert property (p_polarity) else $error("power pin polarity wrong"); // R1
    property p_hold;
        @(posedge clk) disable iff (!reset_n) !(cfg.wr && hit) |=> $stable(gc);
    endproperty
    a_hold: assert property (p_hold) else $error("register changed without write"); // R15
    property p_ctrl_follow;
        @(posedge clk) disable iff (!reset_n) ##1 ctrl == view(gc);
    endproperty
    a_ctrl_follow: assert property (p_ctrl_follow) else $error("control out of step"); // R6
    property p_read;
        @(posedge clk) disable iff (!reset_n)
        (cfg.rd && hit && !cfg.wr) |=> cfg_rvalid && cfg_rdata == $past(gc_view);
    endproperty
    a_read: assert property (p_read) else $error("read data wrong"); // R9
    property p_miss;
        @(posedge clk) disable iff (!reset_n) (cfg.rd && !hit) |=> cfg_rdata == '0;
    endproperty
    a_miss: assert property (p_miss) else $error("unmapped read not zero"); // R10
    c_legacy: cover property (@(posedge clk) disable iff (!reset_n) ctrl.smartcard_style_select);
    c_vpp: cover property (@(posedge clk) disable iff (!reset_n) gc[B_SC_PWR]);
    c_round: cover property (@(posedge clk) disable iff (!reset_n) gc[1:0] == PRI_ROUND);
endmodule : gcarb_top

// ### logic/gcarb_pkg.sv
// Purpose: constants and types for the general control register and arbiter
// Assumes: 16-bit configuration write port with two byte enables, pci clock
// Notes:
// Function
// R1: bit 15 sets media power output polarity
// R2: bit 14 picks smart-card interface style
// R3: style bit reads zero unless arrangement 01
// R4: style and arrangement written together keep style
// R5: bit 13 shortens card-type query time
// R6: bit 12 drives io limit bit 0
// R7: bit 11 drives io base bit 0
// R8: bit 10 names fitted power switch type
// R9: bits 9-8 choose media socket arrangement
// R10: bits 7-3 switch whole functions off
// R11: bit 2 picks smart-card power source
// R12: socket-b vpp source only while socket off
// R13: bits 1-0 choose top bus priority
// R14: media priority uses two round-robin levels
// R15: only global reset clears the register
// R16: round robin rotates past last grant
package gcarb_pkg;
    localparam logic [7:0]  GC_OFFSET      = 8'h86;
    localparam logic [15:0] GC_RESET       = 16'h0003;
    localparam int          B_POL          = 15;
    localparam int          B_STYLE        = 14;
    localparam int          B_FAST         = 13;
    localparam int          B_IOLIM        = 12;
    localparam int          B_IOBASE       = 11;
    localparam int          B_SWITCH       = 10;
    localparam int          B_ARR_HI       = 9;
    localparam int          B_ARR_LO       = 8;
    localparam int          B_SC_OFF       = 7;
    localparam int          B_SD_OFF       = 6;
    localparam int          B_FM_OFF       = 5;
    localparam int          B_SKTB_OFF     = 4;
    localparam int          B_FW_OFF       = 3;
    localparam int          B_SC_PWR       = 2;
    localparam int          B_PRI_HI       = 1;
    localparam int          B_PRI_LO       = 0;
    localparam logic [1:0]  ARR_SEPARATE   = 2'h0;
    localparam logic [1:0]  ARR_TWO_IN_ONE = 2'h1;
    localparam logic [1:0]  ARR_THREE      = 2'h2;
    localparam logic [1:0]  PRI_FIREWIRE   = 2'h0;
    localparam logic [1:0]  PRI_CARDBUS    = 2'h1;
    localparam logic [1:0]  PRI_MEDIA      = 2'h2;
    localparam logic [1:0]  PRI_ROUND      = 2'h3;
    localparam int          NREQ           = 4;
    // requester index: 0 firewire, 1 cardbus, 2 flash media, 3 sd host
    localparam int          RQ_FW          = 0;
    localparam int          RQ_CB          = 1;
    localparam int          RQ_FM          = 2;
    localparam int          RQ_SD          = 3;

    typedef struct packed {
        logic       power_pin_active_high;
        logic       smartcard_style_select;
        logic       fast_query_mode;
        logic       io_limit_bit0;
        logic       io_base_bit0;
        logic       power_switch_type;
        logic [1:0] media_socket_arrangement;
        logic       smartcard_function_off;
        logic       sd_host_function_off;
        logic       media_function_off;
        logic       second_socket_off;
        logic       firewire_function_off;
        logic       smartcard_power_source;
        logic [1:0] bus_priority_select;
    } gcarb_ctrl_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [1:0] byte_en;
        logic [15:0] wdata;
    } gcarb_cfg_t;
endpackage : gcarb_pkg

// ### logic/gcarb_arbiter.sv
// Purpose: top-level bus arbiter among four functions
// Assumes: requests held until granted; grant one cycle per decision
// Notes: fixed, round robin and two-level modes
`timescale 1ns/1ps
module gcarb_arbiter
    import gcarb_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             reset_n,
    input  wire logic [1:0]       mode,
    input  wire logic [NREQ-1:0]  req,
    output logic      [NREQ-1:0]  grant
);
    logic [NREQ-1:0] last;
    logic            media_last_sd;
    logic            card_last_cb;
    logic [NREQ-1:0] next_grant;

    function automatic logic [NREQ-1:0] rr_pick(input logic [NREQ-1:0] r,
                                                input logic [NREQ-1:0] l);
        logic [2*NREQ-1:0] dbl;
        logic [NREQ-1:0]   res;
        int                s;
        int                k;
        res = '0;
        dbl = {r, r};
        s = 0;
        for (k = 0; k < NREQ; k++) begin
            if (l[k]) begin
                s = k + 1;
            end
        end
        for (k = NREQ - 1; k >= 0; k--) begin
            if (dbl[s+k]) begin
                res = '0;
                res[(s + k) % NREQ] = 1'b1;
            end
        end
        return res;
    endfunction : rr_pick

    function automatic logic [NREQ-1:0] fixed_pick(input logic [NREQ-1:0] r, input int top);
        logic [NREQ-1:0] res;
        int              k;
        res = '0;
        for (k = NREQ - 1; k >= 0; k--) begin
            if (r[k]) begin
                res = '0;
                res[k] = 1'b1;
            end
        end
        if (r[top]) begin
            res = '0;
            res[top] = 1'b1;
        end
        return res;
    endfunction : fixed_pick

    always_comb begin
        next_grant = '0;
        case (mode)
            PRI_FIREWIRE: next_grant = fixed_pick(req, RQ_FW); // R13
            PRI_CARDBUS:  next_grant = fixed_pick(req, RQ_CB); // R13
            PRI_MEDIA: begin // R14
                if (req[RQ_FM] && req[RQ_SD]) begin
                    next_grant[media_last_sd ? RQ_FM : RQ_SD] = 1'b1;
                end else if (req[RQ_FM] || req[RQ_SD]) begin
                    next_grant[RQ_FM] = req[RQ_FM];
                    next_grant[RQ_SD] = req[RQ_SD];
                end else if (req[RQ_CB] && req[RQ_FW]) begin
                    next_grant[card_last_cb ? RQ_FW : RQ_CB] = 1'b1;
                end else begin
                    next_grant[RQ_CB] = req[RQ_CB];
                    next_grant[RQ_FW] = req[RQ_FW];
                end
            end
            PRI_ROUND:    next_grant = rr_pick(req, last); // R16
            default:      next_grant = '0;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            grant <= '0;
        end else begin
            grant <= next_grant;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            last          <= '0;
            media_last_sd <= 1'b0;
            card_last_cb  <= 1'b0;
        end else if (|next_grant) begin
            last <= next_grant; // R16
            if (next_grant[RQ_FM] || next_grant[RQ_SD]) begin
                media_last_sd <= next_grant[RQ_SD];
            end
            if (next_grant[RQ_FW] || next_grant[RQ_CB]) begin
                card_last_cb <= next_grant[RQ_CB];
            end
        end
    end

    property p_rr_no_repeat;
        @(posedge clk) disable iff (!reset_n)
        (mode == PRI_ROUND && req == 4'hF && grant != '0 && $past(req) == 4'hF
         && $past(mode) == PRI_ROUND) |=> grant != $past(grant);
    endproperty
    a_rr_no_repeat: assert property (p_rr_no_repeat) else $error("round robin repeated"); // R16
    property p_grant_req;
        @(posedge clk) disable iff (!reset_n) 1'b1 |=> (grant & ~$past(req)) == '0;
    endproperty
    a_grant_req: assert property (p_grant_req) else $error("grant without request"); // R13
    property p_media_first;
        @(posedge clk) disable iff (!reset_n)
        (mode == PRI_MEDIA && (req[RQ_FM] || req[RQ_SD])) |=> !grant[RQ_FW] && !grant[RQ_CB];
    endproperty
    a_media_first: assert property (p_media_first) else $error("media level lost priority"); // R14
    property p_fw_first;
        @(posedge clk) disable iff (!reset_n)
        (mode == PRI_FIREWIRE && req[RQ_FW]) |=> grant[RQ_FW];
    endproperty
    a_fw_first: assert property (p_fw_first) else $error("firewire priority not honoured"); // R13
    property p_onehot;
        @(posedge clk) disable iff (!reset_n) $onehot0(grant);
    endproperty
    a_onehot: assert property (p_onehot) else $error("more than one grant"); // R13
    c_round: cover property (@(posedge clk) disable iff (!reset_n)
        mode == PRI_ROUND && grant[RQ_SD] ##1 grant[RQ_FW]);
    c_media: cover property (@(posedge clk) disable iff (!reset_n)
        mode == PRI_MEDIA && grant[RQ_FM] ##1 grant[RQ_SD]);
endmodule : gcarb_arbiter

// ### sim/gcarb_bench.sv
// Purpose: self-checking bench for the general control register and bus arbiter
// Assumes: 40 MHz clock, async active-low global reset, registered read one cycle after rd
// Notes: inputs move 2 ns after the rising edge, except media_power_request 2'h2 in t_power at 1 ns; outputs are sampled 1 ns after it, at reset release 2 ns
`timescale 1ns/1ps
module gcarb_bench;
    import gcarb_pkg::*;
    logic              clk;
    logic              reset_n;
    gcarb_cfg_t        cfg;
    logic [1:0]        media_power_request;
    logic [NREQ-1:0]   bus_req;
    logic [15:0]       cfg_rdata;
    logic              cfg_rvalid;
    logic [1:0]        media_power_outputs;
    gcarb_ctrl_t       ctrl;
    logic [NREQ-1:0]   bus_grant;
    int                n_errors;
    int                checks_done;

    gcarb_top gcarb_top_i (
        .clk                 (clk),
        .reset_n             (reset_n),
        .cfg                 (cfg),
        .media_power_request (media_power_request),
        .bus_req             (bus_req),
        .cfg_rdata           (cfg_rdata),
        .cfg_rvalid          (cfg_rvalid),
        .media_power_outputs (media_power_outputs),
        .ctrl                (ctrl),
        .bus_grant           (bus_grant)
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic end_of_test();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test

    task automatic check(input logic [15:0] seen, input logic [15:0] expd);
        checks_done++;
        if (seen !== expd) begin
            n_errors++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, expd);
        end
    endtask : check

    task automatic wr_reg(input logic [7:0] a, input logic [15:0] d, input logic [1:0] be = 2'h3);
        @(posedge clk);
        #2;
        cfg.wr      = 1'b1;
        cfg.addr    = a;
        cfg.byte_en = be;
        cfg.wdata   = d;
        @(posedge clk);
        #2;
        cfg.wr = 1'b0;
    endtask : wr_reg

    // reads, then compares data, valid and, at GC_OFFSET only, the control view
    task automatic expect_reg(input logic [7:0] a, input logic [15:0] expd);
        @(posedge clk);
        #2;
        cfg.rd   = 1'b1;
        cfg.addr = a;
        @(posedge clk);
        #1;
        check(cfg_rdata, expd);
        check({15'h0, cfg_rvalid}, 16'h0001);
        if (a == GC_OFFSET) check(16'(ctrl), expd);
        #1;
        cfg.rd = 1'b0;
    endtask : expect_reg

    task automatic pulse_reset();
        @(posedge clk);
        #2;
        reset_n = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check({14'h0, media_power_outputs}, 16'h0003);
        check({12'h0, bus_grant}, 16'h0000);
        #1;
        reset_n = 1'b1;
    endtask : pulse_reset

    task automatic t_fields();
        expect_reg(GC_OFFSET, GC_RESET);
        wr_reg(GC_OFFSET, 16'h3C00, 2'h2);
        expect_reg(GC_OFFSET, 16'h3C03);
        wr_reg(GC_OFFSET, 16'h00F8);
        expect_reg(GC_OFFSET, 16'h00F8);
        wr_reg(GC_OFFSET, 16'h0004);
        expect_reg(GC_OFFSET, 16'h0000);
        wr_reg(GC_OFFSET, 16'h0014);
        expect_reg(GC_OFFSET, 16'h0014);
        wr_reg(8'h84, 16'hFFFF);
        expect_reg(8'h84, 16'h0000);
        expect_reg(GC_OFFSET, 16'h0014);
        pulse_reset();
        expect_reg(GC_OFFSET, GC_RESET);
    endtask : t_fields

    task automatic t_style();
        for (int i = 0; i < 4; i++) begin
            wr_reg(GC_OFFSET, 16'h4000 | 16'(i << 8));
            expect_reg(GC_OFFSET, (i == 1) ? 16'h4100 : 16'(i << 8));
        end
        wr_reg(GC_OFFSET, 16'h4200);
        expect_reg(GC_OFFSET, 16'h0200);
    endtask : t_style

    task automatic t_power();
        media_power_request = 2'h1;
        wr_reg(GC_OFFSET, 16'h0000);
        repeat (2) @(posedge clk);
        #1;
        check({14'h0, media_power_outputs}, 16'h0002);
        wr_reg(GC_OFFSET, 16'h8000);
        repeat (2) @(posedge clk);
        #1;
        check({14'h0, media_power_outputs}, 16'h0001);
        media_power_request = 2'h2;
        repeat (2) @(posedge clk);
        #1;
        check({14'h0, media_power_outputs}, 16'h0002);
    endtask : t_power

    task automatic t_fixed(input logic [1:0] m, input logic [3:0] r, input logic [3:0] g);
        #1;
        bus_req = r;
        wr_reg(GC_OFFSET, {14'h0, m});
        repeat (3) @(posedge clk);
        #1;
        check({12'h0, bus_grant}, {12'h0, g});
    endtask : t_fixed

    // collects four grants; each one-hot and different from the one before
    task automatic t_rotate(input logic [1:0] m, input logic [3:0] r, input logic [3:0] cover_exp);
        logic [3:0] acc;
        logic [3:0] prev;
        acc  = 4'h0;
        prev = 4'h0;
        #1;
        bus_req = r;
        wr_reg(GC_OFFSET, {14'h0, m});
        repeat (2) @(posedge clk);
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            #1;
            check({15'h0, $countones(bus_grant) == 1}, 16'h0001);
            check({15'h0, bus_grant != prev}, 16'h0001);
            prev = bus_grant;
            acc  = acc | bus_grant;
        end
        check({12'h0, acc}, {12'h0, cover_exp});
    endtask : t_rotate

    initial begin
        reset_n             = 1'b0;
        cfg                 = '0;
        media_power_request = 2'h0;
        bus_req             = 4'h0;
        n_errors            = 0;
        checks_done         = 0;
        repeat (5) @(posedge clk);
        #2;
        reset_n = 1'b1;
        check({14'h0, media_power_outputs}, 16'h0003);
        t_fields();
        t_style();
        t_power();
        t_fixed(PRI_FIREWIRE, 4'hF, 4'h1);
        t_fixed(PRI_FIREWIRE, 4'hE, 4'h2);
        t_fixed(PRI_CARDBUS, 4'hF, 4'h2);
        t_fixed(PRI_CARDBUS, 4'hD, 4'h1);
        t_fixed(PRI_MEDIA, 4'hB, 4'h8);
        t_fixed(PRI_ROUND, 4'h0, 4'h0);
        t_rotate(PRI_ROUND, 4'hF, 4'hF);
        t_rotate(PRI_MEDIA, 4'hF, 4'hC);
        t_rotate(PRI_MEDIA, 4'h3, 4'h3);
        end_of_test();
    end

    initial begin
        repeat (3000) @(posedge clk);
        n_errors++;
        end_of_test();
    end
endmodule : gcarb_bench
